// ===== core/hsats_pkg.sv
// Constants, field layouts and state codes of the host scan and aux/temp sequencer.
// Assumes one 40 MHz clock; oscillator timing is counted in half oscillator cycles.
// Notes on behaviour
// [R1] A pen touch raises the internal pen signal and, in pen-interrupt setting, pulls the pin low.
// [R2] In host-controlled scan mode the host sequences each coordinate conversion itself.
// [R3] A coordinate request with the panel drivers off switches the drivers on before the scan.
// [R4] An X or Y conversion runs first overhead, precharge, sense plus 6 cycles, conversion, latency.
// [R5] A Z1 or Z2 conversion runs the same sequence but with the second overhead in front.
// [R6] If the drivers were off when the scan was programmed, panel settle time precedes precharge.
// [R7] Function code 0101 runs one spare-input measurement, code 1000 runs it continuously.
// [R8] Function codes 0110 and 0111 measure the internal temperature sensor.
// [R9] Spare-input and temperature runs use third overhead, conversion and latency, no drivers.
// [R10] Each continuous spare-input measurement lasts as long as a single one.
// [R11] The first overhead is 2.5 oscillator cycles.
// [R12] The second overhead is 3.5 oscillator cycles.
// [R13] Each conversion carries a fixed overhead of 3 oscillator cycles.
package hsats_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] TIME_OFS  = 8'h04;
  localparam logic [7:0] PPRO_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS  = 8'h0c;
  localparam logic [7:0] MASK_OFS  = 8'h10;
  localparam logic [7:0] STATE_OFS = 8'h14;

  // Field positions
  localparam int CTRL_DRV_BIT    = 0;
  localparam int CTRL_PENSET_BIT = 1;
  localparam int CTRL_FUNC_LSB   = 3;
  localparam int TIME_SETTLE_LSB = 0;
  localparam int TIME_PRE_LSB    = 8;
  localparam int TIME_SNS_LSB    = 16;
  localparam int TIME_AVG_LSB    = 24;
  localparam int TIME_RES_BIT    = 28;
  localparam int STAT_PEN_BIT    = 0;
  localparam int STAT_DONE_BIT   = 1;

  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [31:0] TIME_RST = 32'h1101_0101;
  localparam logic [31:0] PPRO_RST = 32'h0000_0002;

  // Converter function codes
  localparam logic [3:0] FN_AUX_SINGLE = 4'h5;
  localparam logic [3:0] FN_FIRST_TEMPERATURE_MEASURE      = 4'h6;
  localparam logic [3:0] FN_SECOND_TEMPERATURE_MEASURE      = 4'h7;
  localparam logic [3:0] FN_AUX_CONT   = 4'h8;
  localparam logic [3:0] FN_SCAN_X     = 4'h9;
  localparam logic [3:0] FN_SCAN_Y     = 4'ha;
  localparam logic [3:0] FN_SCAN_Z1    = 4'hb;
  localparam logic [3:0] FN_SCAN_Z2    = 4'hc;

  // Overheads in oscillator cycles, as figures
  localparam real FIRST_OVERHEAD_CYC   = 2.5;
  localparam real SECOND_OVERHEAD_CYC  = 3.5;
  localparam real THIRD_OVERHEAD_CYC   = 3.5;
  localparam real PRESNS_OVERHEAD_CYC  = 6.0;
  localparam real CONV_OVERHEAD_CYC    = 3.0;

  // Same overheads in half oscillator cycles
  localparam logic [15:0] OH1_HALF    = 16'(int'(FIRST_OVERHEAD_CYC * 2.0));
  localparam logic [15:0] OH2_HALF    = 16'(int'(SECOND_OVERHEAD_CYC * 2.0));
  localparam logic [15:0] OH3_HALF    = 16'(int'(THIRD_OVERHEAD_CYC * 2.0));
  localparam logic [15:0] OHDLY2_HALF = 16'(int'(PRESNS_OVERHEAD_CYC * 2.0));
  localparam logic [15:0] OHCONV_HALF = 16'(int'(CONV_OVERHEAD_CYC * 2.0));

  // Converter clocks per sample, resolution plus 2
  localparam logic [7:0] RES12_CLKS = 8'h0e;
  localparam logic [7:0] RES10_CLKS = 8'h0c;

  typedef enum logic [1:0] {
    KIND_XY  = 2'b00,
    KIND_Z   = 2'b01,
    KIND_AUX = 2'b10
  } hsats_kind_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_OVH    = 3'b001,
    S_SETTLE = 3'b010,
    S_PRESNS = 3'b011,
    S_CONV   = 3'b100,
    S_CONVOH = 3'b101,
    S_PPRO   = 3'b110
  } hsats_state_t;

endpackage

// ===== core/hsats_sync.sv
// Two-stage synchroniser with a rising-edge pulse behind it.
// Assumes the input is asynchronous to clk_i; only stage two feeds logic.
`timescale 1ns/1ps
module hsats_sync (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // First stage read only by the second
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~last_reg;
endmodule // hsats_sync

// ===== core/hsats_top.sv
// Host-controlled scan and aux/temperature conversion sequencer with AXI4-Lite registers.
// Assumes pen and converter clock arrive asynchronously; analog front end lies outside.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module hsats_top import hsats_pkg::*; #(
  parameter int OSC_HALF_DIV = 2
) (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        pen_touch_i,
  input  wire logic        conv_clk_i,
  output logic             pen_irq_data_ready_pin_n_o,
  output logic             drivers_on_o,
  output logic             adc_run_o,
  output logic             sample_done_o,
  output logic             irq_o
);
  initial begin
    if (OSC_HALF_DIV < 1 || OSC_HALF_DIV > 255) $error("OSC_HALF_DIV out of range");
  end

  hsats_state_t state_reg, state_next;
  hsats_kind_t  kind_reg;
  logic [15:0]  cnt_reg, cnt_next;
  logic [7:0]   div_reg;
  logic         half_tick_reg;
  logic         cont_reg;
  logic         settle_reg;
  logic         drv_on_reg;
  logic [31:0]  ctrl_reg, time_reg, ppro_reg;
  logic [1:0]   stat_reg, mask_reg;
  logic         aw_have_reg, w_have_reg;
  logic [7:0]   aw_addr_reg;
  logic [31:0]  w_data_reg;
  logic [3:0]   w_strb_reg;
  logic         pen_lvl, pen_rise, conv_lvl, conv_rise;
  logic         wr_fire, start, st_leave, done_now;
  logic [31:0]  wmask, wr_merged;
  logic [3:0]   wr_func, cur_func;
  hsats_kind_t  wr_kind;
  logic [7:0]   conv_total;
  logic [15:0]  presns_len, settle_len;

  // Pen and converter clock come from outside this clock's domain
  hsats_sync u_pen_sync (
    .clk_i   (mclk_i),
    .reset_i (reset_i),
    .async_i (pen_touch_i),
    .level_o (pen_lvl),
    .rise_o  (pen_rise)
  );
  hsats_sync u_conv_sync (
    .clk_i   (mclk_i),
    .reset_i (reset_i),
    .async_i (conv_clk_i),
    .level_o (conv_lvl),
    .rise_o  (conv_rise)
  );

  // Half oscillator cycle enable; 2.5 and 3.5 cycle overheads need half steps
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      div_reg       <= 8'h00;
      half_tick_reg <= 1'b0;
    end else if (div_reg == 8'(OSC_HALF_DIV - 1)) begin
      div_reg       <= 8'h00;
      half_tick_reg <= 1'b1;
    end else begin
      div_reg       <= div_reg + 8'h01;
      half_tick_reg <= 1'b0;
    end
  end

  // Function code decode
  function automatic logic fn_valid(input logic [3:0] f);
    return (f >= FN_AUX_SINGLE) && (f <= FN_SCAN_Z2);
  endfunction
  function automatic hsats_kind_t fn_kind(input logic [3:0] f);
    if (f == FN_SCAN_X || f == FN_SCAN_Y) return KIND_XY;
    else if (f == FN_SCAN_Z1 || f == FN_SCAN_Z2) return KIND_Z;
    else return KIND_AUX;
  endfunction
  function automatic logic [15:0] at_least_one(input logic [15:0] v);
    return (v == 16'h0000) ? 16'h0001 : v;
  endfunction

  // Byte-lane mask from the strobes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{w_strb_reg[gi]}};
    end
  endgenerate

  assign wr_fire    = aw_have_reg & w_have_reg & ~s_axi_bvalid_o;
  assign wr_func    = w_data_reg[CTRL_FUNC_LSB +: 4];
  assign wr_kind    = fn_kind(wr_func);
  assign cur_func   = ctrl_reg[CTRL_FUNC_LSB +: 4];
  assign wr_merged  = (ctrl_reg & ~wmask) | (w_data_reg & wmask);
  assign start      = wr_fire && (aw_addr_reg == CTRL_OFS) && (state_reg == S_IDLE)
                      && w_strb_reg[0] && fn_valid(wr_func);
  // Samples times (resolution + 2) converter clocks
  assign conv_total = 8'({4'h0, time_reg[TIME_AVG_LSB +: 4]}
                      * (time_reg[TIME_RES_BIT] ? RES12_CLKS : RES10_CLKS));
  assign presns_len = 16'({7'h00, time_reg[TIME_PRE_LSB +: 8], 1'b0})
                      + 16'({7'h00, time_reg[TIME_SNS_LSB +: 8], 1'b0}) + OHDLY2_HALF;
  assign settle_len = at_least_one(16'({7'h00, time_reg[TIME_SETTLE_LSB +: 8], 1'b0}));
  assign st_leave   = state_next != state_reg;
  assign done_now   = (state_reg == S_PPRO) && st_leave;

  // Sequencer next state; timed phases step on half ticks, conversion on converter edges
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      S_IDLE: begin
        if (start) begin
          state_next = S_OVH;
          if (wr_kind == KIND_XY) cnt_next = OH1_HALF;        // see [R11]
          else if (wr_kind == KIND_Z) cnt_next = OH2_HALF;    // see [R12]
          else cnt_next = OH3_HALF;                           // see [R9]
        end
      end
      S_OVH: begin
        if (half_tick_reg && cnt_reg == 16'h0001) begin
          if (kind_reg == KIND_AUX) begin
            state_next = S_CONV;                              // see [R9]
            cnt_next   = at_least_one({8'h00, conv_total});
          end else if (settle_reg) begin
            state_next = S_SETTLE;                            // see [R6]
            cnt_next   = settle_len;
          end else begin
            state_next = S_PRESNS;                            // see [R4] see [R5]
            cnt_next   = presns_len;
          end
        end else if (half_tick_reg) begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      S_SETTLE, S_PRESNS, S_CONVOH, S_PPRO: begin
        if (half_tick_reg && cnt_reg == 16'h0001) begin
          if (state_reg == S_SETTLE) begin
            state_next = S_PRESNS;
            cnt_next   = presns_len;
          end else if (state_reg == S_PRESNS) begin
            state_next = S_CONV;
            cnt_next   = at_least_one({8'h00, conv_total});
          end else if (state_reg == S_CONVOH) begin
            state_next = S_PPRO;
            cnt_next   = at_least_one({7'h00, ppro_reg[7:0], 1'b0});
          end else if (cont_reg && cur_func == FN_AUX_CONT) begin
            state_next = S_OVH;                               // see [R10]
            cnt_next   = OH3_HALF;
          end else begin
            state_next = S_IDLE;
          end
        end else if (half_tick_reg) begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      S_CONV: begin
        if (conv_rise && cnt_reg == 16'h0001) begin
          state_next = S_CONVOH;                              // see [R13]
          cnt_next   = OHCONV_HALF;
        end else if (conv_rise) begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // Sequencer state and the run's kind
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg  <= S_IDLE;
      cnt_reg    <= 16'h0000;
      kind_reg   <= KIND_XY;
      cont_reg   <= 1'b0;
      settle_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (start) begin
        kind_reg   <= wr_kind;                                // see [R7] see [R8]
        cont_reg   <= (wr_func == FN_AUX_CONT);               // see [R7]
        settle_reg <= (wr_kind != KIND_AUX) && !drv_on_reg;   // see [R6]
      end
    end
  end

  // Drivers: software may switch them, a scan request forces them on
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      drv_on_reg <= 1'b0;
    end else if (start && wr_kind != KIND_AUX) begin
      drv_on_reg <= 1'b1;                                     // see [R3]
    end else if (wr_fire && aw_addr_reg == CTRL_OFS && w_strb_reg[0]) begin
      drv_on_reg <= w_data_reg[CTRL_DRV_BIT];
    end
  end

  // Configuration registers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_reg <= CTRL_RST;
      time_reg <= TIME_RST;
      ppro_reg <= PPRO_RST;
      mask_reg <= 2'b00;
    end else if (wr_fire) begin
      if (aw_addr_reg == CTRL_OFS) begin
        ctrl_reg <= wr_merged & 32'h0000_007b;
      end else if (aw_addr_reg == TIME_OFS) begin
        time_reg <= ((time_reg & ~wmask) | (w_data_reg & wmask)) & 32'h1fff_ffff;
      end else if (aw_addr_reg == PPRO_OFS) begin
        ppro_reg <= ((ppro_reg & ~wmask) | (w_data_reg & wmask)) & 32'h0000_00ff;
      end else if (aw_addr_reg == MASK_OFS && w_strb_reg[0]) begin
        mask_reg <= w_data_reg[1:0];
      end
    end
  end

  // Sticky events; a set in the clearing cycle survives
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stat_reg <= 2'b00;
    end else begin
      stat_reg <= (stat_reg & ~((wr_fire && aw_addr_reg == STAT_OFS && w_strb_reg[0])
                  ? w_data_reg[1:0] : 2'b00)) | {done_now, pen_rise};
    end
  end

  // Registered pin and status outputs
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pen_irq_data_ready_pin_n_o <= 1'b1;
      drivers_on_o               <= 1'b0;
      adc_run_o                  <= 1'b0;
      sample_done_o              <= 1'b0;
      irq_o                      <= 1'b0;
    end else begin
      // Pin shows pen touch or data ready, chosen by the pen setting
      pen_irq_data_ready_pin_n_o <= ctrl_reg[CTRL_PENSET_BIT] ? ~pen_lvl    // see [R1]
                                    : ~stat_reg[STAT_DONE_BIT];
      drivers_on_o               <= drv_on_reg;
      adc_run_o                  <= (state_next == S_CONV);
      sample_done_o              <= done_now;
      irq_o                      <= |(stat_reg & mask_reg);
    end
  end

  // AXI4-Lite write: address and data taken in either order
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      aw_have_reg     <= 1'b0;
      w_have_reg      <= 1'b0;
      aw_addr_reg     <= 8'h00;
      w_data_reg      <= 32'h0000_0000;
      w_strb_reg      <= 4'h0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= 2'b00;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_addr_reg     <= s_axi_awaddr_i;
        aw_have_reg     <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_data_reg     <= s_axi_wdata_i;
        w_strb_reg     <= s_axi_wstrb_i;
        w_have_reg     <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_reg    <= 1'b0;
        w_have_reg     <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // Unmapped or unaligned offsets answer with a slave error
        s_axi_bresp_o  <= (aw_addr_reg > STATE_OFS || aw_addr_reg[1:0] != 2'b00)
                          ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read: one outstanding, data one cycle after the address
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= 2'b00;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rresp_o   <= 2'b00;
      if (s_axi_araddr_i == CTRL_OFS) s_axi_rdata_o <= ctrl_reg;
      else if (s_axi_araddr_i == TIME_OFS) s_axi_rdata_o <= time_reg;
      else if (s_axi_araddr_i == PPRO_OFS) s_axi_rdata_o <= ppro_reg;
      else if (s_axi_araddr_i == STAT_OFS) s_axi_rdata_o <= {30'h0, stat_reg};
      else if (s_axi_araddr_i == MASK_OFS) s_axi_rdata_o <= {30'h0, mask_reg};
      else if (s_axi_araddr_i == STATE_OFS) begin
        s_axi_rdata_o <= {25'h0, pen_lvl, state_reg != S_IDLE, drv_on_reg, 1'b0, state_reg};
      end else begin
        s_axi_rdata_o <= 32'h0000_0000;
        s_axi_rresp_o <= 2'b10;
      end
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // Half ticks spent in the current phase, for the checks below
  logic [15:0] age_reg;
  always_ff @(posedge mclk_i) begin
    if (reset_i || st_leave) age_reg <= 16'h0000;
    else if (half_tick_reg) age_reg <= age_reg + 16'h0001;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  chk_pen_pin_low: assert property (pen_lvl && ctrl_reg[CTRL_PENSET_BIT] // see [R1]
    |=> !pen_irq_data_ready_pin_n_o) else $error("pen touch did not pull pin low");
  chk_drv_auto_on: assert property (start && wr_kind != KIND_AUX // see [R3]
    |=> drv_on_reg ##1 drivers_on_o) else $error("drivers not forced on");
  chk_xy_oh_len: assert property (state_reg == S_OVH && st_leave && kind_reg == KIND_XY // see [R11]
    |-> age_reg == OH1_HALF - 16'h0001) else $error("first overhead length wrong");
  chk_z_oh_len: assert property (state_reg == S_OVH && st_leave && kind_reg == KIND_Z // see [R12]
    |-> age_reg == OH2_HALF - 16'h0001) else $error("second overhead length wrong");
  chk_aux_oh_len: assert property (state_reg == S_OVH && st_leave && kind_reg == KIND_AUX // see [R9]
    |-> age_reg == OH3_HALF - 16'h0001 ##1 state_reg == S_CONV)
    else $error("third overhead or skip wrong");
  chk_presns_len: assert property (state_reg == S_PRESNS && st_leave // see [R4]
    |-> age_reg == presns_len - 16'h0001 ##1 state_reg == S_CONV)
    else $error("precharge and sense length wrong");
  chk_z_path: assert property (state_reg == S_OVH && st_leave && kind_reg == KIND_Z // see [R5]
    && !settle_reg |=> state_reg == S_PRESNS) else $error("pressure path wrong");
  chk_settle_first: assert property (state_reg == S_OVH && st_leave && settle_reg // see [R6]
    |=> state_reg == S_SETTLE) else $error("settle phase missing");
  chk_aux_start: assert property (start && wr_func == FN_AUX_SINGLE // see [R7]
    |=> state_reg == S_OVH && kind_reg == KIND_AUX && !cont_reg)
    else $error("single aux not started");
  chk_temp_start: assert property (start && (wr_func == FN_FIRST_TEMPERATURE_MEASURE || wr_func == FN_SECOND_TEMPERATURE_MEASURE) // see [R8]
    |=> state_reg == S_OVH && kind_reg == KIND_AUX && $stable(drv_on_reg))
    else $error("temperature run wrong");
  chk_cont_repeat: assert property (done_now && cont_reg && cur_func == FN_AUX_CONT // see [R10]
    |=> state_reg == S_OVH && cnt_reg == OH3_HALF) else $error("continuous run did not repeat");
  chk_conv_ovh: assert property (state_reg == S_CONVOH && st_leave // see [R13]
    |-> age_reg == OHCONV_HALF - 16'h0001) else $error("conversion overhead wrong");

  cov_xy_scan: cover property (start && wr_kind == KIND_XY ##[1:1000] done_now);
  cov_settle: cover property (state_reg == S_SETTLE);
  cov_cont_aux: cover property (done_now && cont_reg ##1 state_reg == S_OVH);
endmodule // hsats_top

// ===== sim/hsats_panel_model.sv
// Panel-side model: source of the converter clock seen by the sequencer.
// Assumes the clock only runs while a conversion phase is under way.
`timescale 1ns/1ps
module hsats_panel_model (
  input  wire logic adc_run_i,
  output logic      conv_clk_o
);
  // 200 ns converter clock, still between frames; offset keeps edges off mclk edges
  initial begin
    conv_clk_o = 1'b0;
    forever begin
      @(posedge adc_run_i);
      #10;
      while (adc_run_i === 1'b1) begin
        #100 conv_clk_o = ~conv_clk_o;
      end
      conv_clk_o = 1'b0;
    end
  end
endmodule // hsats_panel_model

// ===== sim/testbench.sv
// Self-checking bench: host on AXI4-Lite sequences each conversion itself, except the repeating continuous aux run.
// Assumes the panel model clocks the converter; oscillator divider set to 1.
`timescale 1ns/1ps
module testbench import hsats_pkg::*; ;
  localparam int DIV = 1;
  logic        mclk_i, reset_i, pen_touch_i, conv_clk_i, seen_drv;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd_q;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
  logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic        pen_irq_data_ready_pin_n_o, drivers_on_o, adc_run_o, sample_done_o, irq_o;
  logic [3:0]  fns [6] = '{FN_SCAN_Y, FN_SCAN_Z1, FN_SCAN_Z2, FN_AUX_SINGLE, FN_FIRST_TEMPERATURE_MEASURE, FN_SECOND_TEMPERATURE_MEASURE};
  int          offs [6] = '{0, 2, 2, -14, -14, -14};
  int          failures, n_checks, base, t, t2;

  hsats_top #(.OSC_HALF_DIV(DIV)) dut_u (
    .mclk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .pen_touch_i, .conv_clk_i,
    .pen_irq_data_ready_pin_n_o, .drivers_on_o, .adc_run_o, .sample_done_o, .irq_o
  );
  hsats_panel_model panel_u (.adc_run_i(adc_run_o), .conv_clk_o(conv_clk_i));

  // 40 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      s_axi_awvalid_i <= s_axi_awvalid_i & ~s_axi_awready_o;
      s_axi_wvalid_i <= s_axi_wvalid_i & ~s_axi_wready_o;
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    resp = s_axi_bresp_o;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      s_axi_arvalid_i <= s_axi_arvalid_i & ~s_axi_arready_o;
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    rd_q = s_axi_rdata_o;
    resp = s_axi_rresp_o;
  endtask

  // Cycles to the next done pulse; notes whether the drivers ever came on
  task automatic wait_done(output int cyc);
    cyc = 0;
    seen_drv = 1'b0;
    do begin
      @(posedge mclk_i);
      cyc++;
      seen_drv = seen_drv | (drivers_on_o === 1'b1);
    end while (sample_done_o !== 1'b1 && cyc < 5000);
  endtask

  // Start one function; pen-interrupt setting kept on
  task automatic meas(input logic [3:0] fn, input logic drv, output int cyc);
    wr(CTRL_OFS, {25'h0, fn, 2'b01, drv});
    wait_done(cyc);
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Run is short; this span is many times what the tests need
  initial begin
    #400000;
    failures++;
    finish_test();
  end

  // Host-side sequence: each conversion requested one at a time, except the repeating continuous aux run
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} <= '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} <= '0;
    s_axi_wstrb_i <= 4'hf;
    pen_touch_i <= 1'b0;
    reset_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(CTRL_OFS);
    chk(rd_q, CTRL_RST);
    rd(TIME_OFS);
    chk(rd_q, TIME_RST);
    rd(PPRO_OFS);
    chk(rd_q, PPRO_RST);
    rd(8'h18);
    chk({rd_q[29:0], resp}, 32'h2);
    wr(MASK_OFS, 32'h1);
    pen_touch_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk({pen_irq_data_ready_pin_n_o, irq_o}, 2'b01);
    pen_touch_i <= 1'b0;
    wr(STAT_OFS, 32'h3);
    repeat (6) @(posedge mclk_i);
    chk({pen_irq_data_ready_pin_n_o, irq_o}, 2'b10);
    meas(FN_SCAN_X, 1'b0, t);
    chk(seen_drv, 1'b1);
    meas(FN_SCAN_X, 1'b1, base);
    chk(t - base, 2 * DIV);
    // Durations relative to an X scan with drivers already on
    for (int i = 0; i < 6; i++) begin
      meas(fns[i], fns[i] >= FN_SCAN_X, t);
      chk(t, base + offs[i] * DIV);
      chk(seen_drv, fns[i] >= FN_SCAN_X);
    end
    meas(FN_AUX_CONT, 1'b0, t);
    chk(t, base - 14 * DIV);
    wait_done(t);
    wait_done(t2);
    chk(t2, t);
    wr(CTRL_OFS, 32'h2);
    wait_done(t);
    repeat (3) @(posedge mclk_i);
    chk(irq_o, 1'b0);
    wr(MASK_OFS, 32'h2);
    repeat (3) @(posedge mclk_i);
    chk(irq_o, 1'b1);
    wr(STAT_OFS, 32'h2);
    repeat (3) @(posedge mclk_i);
    chk(irq_o, 1'b0);
    finish_test();
  end
endmodule // testbench
